// *** logic/dac_regs_pkg.sv ***
// constants, field layout and reset values for the shared dac register bank
// Function
// - channel code unsigned, left-justified in bits 15-4
// - ten-bit variant uses top ten field bits
// - setup bit 15 selects latching window comparator
// - setup bit 14 locks all registers
// - password field bits 15-12, only 0101 accepted
// - setup bit 13 picks dump address 00/01
// - setup bit 12 enables internal reference
// - two-bit voltage power fields, reset to 11
// - one-bit current power controls, reset to 1
// - 1010 in bits 11-8 triggers full reset
// - action bit 7 loads synchronous channels
// - action bit 6 clears codes zero or mid
// - action bit 4 starts fault dump
// - action bit 3 triggers protect
// - action bit 2 reads one store row
// - action bit 1 programs the store
// - action bit 0 reloads from store
// - channel codes at 1Ch and 19h
// - setup register at 1Fh
// - action register at 20h
package dac_regs_pkg;
    localparam logic [7:0] ADDR_CODE0 = 8'h1C;
    localparam logic [7:0] ADDR_CODE1 = 8'h19;
    localparam logic [7:0] ADDR_SETUP = 8'h1F;
    localparam logic [7:0] ADDR_ACTION = 8'h20;
    localparam logic [7:0] PM_PAGE_CH0 = 8'h03;
    localparam logic [7:0] PM_PAGE_CH1 = 8'h00;
    localparam logic [7:0] PM_PAGE_COMMON = 8'hFF;
    localparam logic [7:0] PM_CMD_CODE = 8'h21;
    localparam logic [7:0] PM_CMD_SETUP = 8'hE3;
    localparam logic [7:0] PM_CMD_ACTION = 8'hE4;
    localparam logic [15:0] RST_CODE = 16'h0000;
    localparam logic [15:0] RST_SETUP = 16'h0FFF;
    localparam logic [15:0] SETUP_RW_MASK = 16'hFE07;
    localparam int BIT_HOLD = 15;
    localparam int BIT_LOCK = 14;
    localparam int BIT_DUMP_SEL = 13;
    localparam int BIT_INT_REF = 12;
    localparam int BIT_VPWR0_LO = 10;
    localparam int BIT_IPWR0 = 9;
    localparam int BIT_VPWR1_LO = 1;
    localparam int BIT_IPWR1 = 0;
    localparam int PW_HI = 15;
    localparam int PW_LO = 12;
    localparam logic [3:0] PASSWORD = 4'h5;
    localparam int RST_HI = 11;
    localparam int RST_LO = 8;
    localparam logic [3:0] RESET_KEY = 4'hA;
    localparam int BIT_LOAD = 7;
    localparam int BIT_CLEAR = 6;
    localparam int BIT_DUMP = 4;
    localparam int BIT_PROTECT = 3;
    localparam int BIT_ROW_READ = 2;
    localparam int BIT_PROGRAM = 1;
    localparam int BIT_RELOAD = 0;
    localparam int CODE_LSB = 4;
    localparam int NUM_TRIG = 6;
    localparam int NUM_CH = 2;
endpackage

// *** logic/dac_trig_if.sv ***
// trigger pulses carried from the register decode to the pulse register
`timescale 1ns/1ps
interface dac_trig_if;
    logic [dac_regs_pkg::NUM_TRIG-1:0] fire;
    logic [dac_regs_pkg::NUM_TRIG-1:0] pulse;
    modport src (output fire, input pulse);
    modport dst (input fire, output pulse);
endinterface

// *** logic/dac_trig_pulse.sv ***
// registers one-cycle action pulses so outputs come from flip-flops
`timescale 1ns/1ps
module dac_trig_pulse (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    dac_trig_if.dst trig
);
    import dac_regs_pkg::*;
    logic [NUM_TRIG-1:0] pulse_reg;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pulse_reg <= '0;
        end else begin
            pulse_reg <= trig.fire;
        end
    end
    assign trig.pulse = pulse_reg;
endmodule

// *** logic/dac_common_regs.sv ***
// register bank: channel codes, shared setup and shared action registers
`timescale 1ns/1ps
module dac_common_regs #(
    parameter int CODE_BITS = 12
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic pmbus_i,
    input wire logic [7:0] page_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [dac_regs_pkg::NUM_CH-1:0] sync_cfg_i,
    input wire logic [dac_regs_pkg::NUM_CH-1:0] clear_value_select_i,
    output logic [15:0] rdata_o,
    output logic rvalid_o,
    output logic [CODE_BITS-1:0] code0_o,
    output logic [CODE_BITS-1:0] code1_o,
    output logic window_compare_hold_o,
    output logic register_lock_o,
    output logic dump_read_select_o,
    output logic int_ref_en_o,
    output logic [1:0] voltage_output_power0_o,
    output logic [1:0] voltage_output_power1_o,
    output logic current_output_power0_o,
    output logic current_output_power1_o,
    output logic soft_reset_o,
    output logic simultaneous_load_o,
    output logic [dac_regs_pkg::NUM_CH-1:0] load_ch_o,
    output logic output_clear_o,
    output logic fault_dump_o,
    output logic protect_o,
    output logic snapshot_row_read_o,
    output logic store_program_o,
    output logic store_reload_o
);
    import dac_regs_pkg::*;

    localparam int FIELD_MSB = 15;
    localparam int FIELD_LSB = FIELD_MSB - CODE_BITS + 1;

    logic [15:0] code0_reg;
    logic [15:0] code1_reg;
    logic [15:0] setup_reg;
    logic unlock_armed_reg;
    logic [15:0] rdata_reg;
    logic rvalid_reg;
    logic soft_reset_reg;
    logic [NUM_CH-1:0] load_ch_reg;
    logic simultaneous_load_reg;
    logic [15:0] code0_next;
    logic [15:0] code1_next;
    logic [15:0] setup_next;
    logic unlock_armed_next;

    // decoding: address map differs between plain and paged access
    function automatic logic hit(input logic pm, input logic [7:0] pg, input logic [7:0] ad,
                                 input logic [7:0] raw, input logic [7:0] pgsel,
                                 input logic [7:0] cmd);
        hit = pm ? (pg == pgsel && ad == cmd) : (ad == raw);
    endfunction

    wire sel_code0 = hit(pmbus_i, page_i, addr_i, ADDR_CODE0, PM_PAGE_CH0, PM_CMD_CODE);
    wire sel_code1 = hit(pmbus_i, page_i, addr_i, ADDR_CODE1, PM_PAGE_CH1, PM_CMD_CODE);
    wire sel_setup = hit(pmbus_i, page_i, addr_i, ADDR_SETUP, PM_PAGE_COMMON,
                         PM_CMD_SETUP);
    wire sel_action = hit(pmbus_i, page_i, addr_i, ADDR_ACTION, PM_PAGE_COMMON,
                          PM_CMD_ACTION);

    wire locked = setup_reg[BIT_LOCK];
    wire wr_code0 = wr_en_i && sel_code0 && !locked;
    wire wr_code1 = wr_en_i && sel_code1 && !locked;
    wire wr_setup = wr_en_i && sel_setup;
    wire wr_action = wr_en_i && sel_action;
    wire pw_ok = wdata_i[PW_HI:PW_LO] == PASSWORD;
    wire act_ok = wr_action && !locked;
    // while locked, only clearing the lock after a password is honoured
    wire unlock_write = wr_setup && locked && unlock_armed_reg && !wdata_i[BIT_LOCK];
    wire setup_take = wr_setup && !locked;

    wire [15:0] code_mask = {{CODE_BITS{1'b1}}, {(16 - CODE_BITS){1'b0}}};
    wire [15:0] code_mid = 16'h8000;
    wire do_reset = act_ok && wdata_i[RST_HI:RST_LO] == RESET_KEY;
    wire do_load = act_ok && wdata_i[BIT_LOAD];
    wire do_clear = act_ok && wdata_i[BIT_CLEAR];

    always_comb begin
        code0_next = code0_reg;
        code1_next = code1_reg;
        if (wr_code0) begin
            code0_next = wdata_i & code_mask;
        end
        if (wr_code1) begin
            code1_next = wdata_i & code_mask;
        end
        if (do_clear) begin
            code0_next = clear_value_select_i[0] ? code_mid : RST_CODE;
            code1_next = clear_value_select_i[1] ? code_mid : RST_CODE;
        end
    end

    always_comb begin
        setup_next = setup_reg;
        unlock_armed_next = unlock_armed_reg;
        if (setup_take) begin
            setup_next = (wdata_i & SETUP_RW_MASK) | (RST_SETUP & ~SETUP_RW_MASK);
        end else if (unlock_write) begin
            setup_next[BIT_LOCK] = 1'b0;
        end
        if (wr_action && locked) begin
            unlock_armed_next = pw_ok;
        end else if (!locked) begin
            unlock_armed_next = 1'b0;
        end
    end

    // the password field itself stores nothing; only the armed flag remembers it
    wire [15:0] rd_mux = sel_code0 ? code0_reg :
                         sel_code1 ? code1_reg :
                         sel_setup ? setup_reg : 16'h0000;

    dac_trig_if trig ();
    assign trig.fire = {act_ok && wdata_i[BIT_DUMP],
                        act_ok && wdata_i[BIT_PROTECT],
                        act_ok && wdata_i[BIT_ROW_READ],
                        act_ok && wdata_i[BIT_PROGRAM],
                        act_ok && wdata_i[BIT_RELOAD],
                        do_clear};
    dac_trig_pulse u_pulse (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .trig(trig)
    );

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            code0_reg <= RST_CODE;
            code1_reg <= RST_CODE;
            setup_reg <= RST_SETUP;
            unlock_armed_reg <= 1'b0;
        end else if (do_reset) begin
            // soft reset restores the whole bank as at power-on
            code0_reg <= RST_CODE;
            code1_reg <= RST_CODE;
            setup_reg <= RST_SETUP;
            unlock_armed_reg <= 1'b0;
        end else begin
            code0_reg <= code0_next;
            code1_reg <= code1_next;
            setup_reg <= setup_next;
            unlock_armed_reg <= unlock_armed_next;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_reg <= 16'h0000;
            rvalid_reg <= 1'b0;
            soft_reset_reg <= 1'b0;
            load_ch_reg <= '0;
            simultaneous_load_reg <= 1'b0;
        end else begin
            rdata_reg <= rd_en_i ? rd_mux : rdata_reg;
            rvalid_reg <= rd_en_i;
            soft_reset_reg <= do_reset;
            load_ch_reg <= do_load ? sync_cfg_i : '0;
            // own flop so the summary pulse is not a gate behind the per-channel flops
            simultaneous_load_reg <= do_load && (|sync_cfg_i);
        end
    end

    assign rdata_o = rdata_reg;
    assign rvalid_o = rvalid_reg;
    assign code0_o = code0_reg[FIELD_MSB:FIELD_LSB];
    assign code1_o = code1_reg[FIELD_MSB:FIELD_LSB];
    assign window_compare_hold_o = setup_reg[BIT_HOLD];
    assign register_lock_o = setup_reg[BIT_LOCK];
    assign dump_read_select_o = setup_reg[BIT_DUMP_SEL];
    assign int_ref_en_o = setup_reg[BIT_INT_REF];
    assign voltage_output_power0_o = setup_reg[BIT_VPWR0_LO+1:BIT_VPWR0_LO];
    assign voltage_output_power1_o = setup_reg[BIT_VPWR1_LO+1:BIT_VPWR1_LO];
    assign current_output_power0_o = setup_reg[BIT_IPWR0];
    assign current_output_power1_o = setup_reg[BIT_IPWR1];
    assign soft_reset_o = soft_reset_reg;
    assign load_ch_o = load_ch_reg;
    assign simultaneous_load_o = simultaneous_load_reg;
    assign fault_dump_o = trig.pulse[5];
    assign protect_o = trig.pulse[4];
    assign snapshot_row_read_o = trig.pulse[3];
    assign store_program_o = trig.pulse[2];
    assign store_reload_o = trig.pulse[1];
    assign output_clear_o = trig.pulse[0];
endmodule

// *** tb/dac_common_regs_props.sv ***
// port-level checks on the dac register bank
`timescale 1ns/1ps
module dac_common_regs_props import dac_regs_pkg::*; #(
    parameter int CODE_BITS = 12
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic pmbus_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [1:0] sync_cfg_i,
    input wire logic [15:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic [CODE_BITS-1:0] code0_o,
    input wire logic window_compare_hold_o,
    input wire logic register_lock_o,
    input wire logic dump_read_select_o,
    input wire logic int_ref_en_o,
    input wire logic soft_reset_o,
    input wire logic [1:0] load_ch_o,
    input wire logic fault_dump_o,
    input wire logic output_clear_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    // plain decode only; paged accesses are checked by the bench
    wire logic wr_ok = wr_en_i && !pmbus_i && !register_lock_o;
    wire logic act = wr_ok && addr_i == ADDR_ACTION && wdata_i[11:8] != RESET_KEY;
    a_read_valid: assert property (rd_en_i |=> rvalid_o)
        else $error("read not answered");
    a_action_zero: assert property (rd_en_i && !pmbus_i && !wr_en_i
        && addr_i == ADDR_ACTION |=> rdata_o == 16'h0000) else $error("action reads nonzero");
    a_setup_fields: assert property (wr_ok && addr_i == ADDR_SETUP |=>
        {window_compare_hold_o, register_lock_o, dump_read_select_o, int_ref_en_o}
        == $past(wdata_i[15:12])) else $error("setup field mismatch");
    a_code_left: assert property (wr_ok && addr_i == ADDR_CODE0 |=>
        code0_o == $past(wdata_i[15 -: CODE_BITS])) else $error("code alignment");
    a_lock_hold: assert property (register_lock_o && wr_en_i && !pmbus_i
        && addr_i == ADDR_CODE0 |=> $stable(code0_o)) else $error("locked code changed");
    // the pulse flop takes the write edge itself, so the pulse shows one cycle later
    a_dump_pulse: assert property (act && wdata_i[BIT_DUMP] |=> fault_dump_o
        ##1 (!fault_dump_o || $past(act && wdata_i[BIT_DUMP])))
        else $error("dump pulse wrong");
    a_clear_quiet: assert property (act && !wdata_i[BIT_CLEAR] |=> !output_clear_o)
        else $error("clear without request");
    a_load_select: assert property (act && wdata_i[BIT_LOAD]
        |=> load_ch_o == $past(sync_cfg_i)) else $error("load channel mismatch");
    a_reset_fire: assert property (wr_ok && addr_i == ADDR_ACTION
        && wdata_i[11:8] == RESET_KEY |=> soft_reset_o) else $error("soft reset missing");
    c_dump: cover property (fault_dump_o);
    c_reset: cover property (soft_reset_o);
    c_lock: cover property ($fell(register_lock_o));
endmodule
bind dac_common_regs dac_common_regs_props #(.CODE_BITS(CODE_BITS)) u_props (.*);

// *** tb/dac_host_model.sv ***
// host controller model issuing register accesses
`timescale 1ns/1ps
module dac_host_model (
    input wire logic core_clk_i,
    input wire logic rvalid_i,
    input wire logic [15:0] rdata_i,
    output logic wr_en_o,
    output logic rd_en_o,
    output logic pmbus_o,
    output logic [7:0] page_o,
    output logic [7:0] addr_o,
    output logic [15:0] wdata_o
);
    initial begin
        {wr_en_o, rd_en_o, pmbus_o, page_o, addr_o, wdata_o} = '0;
    end
    // idle address and data lines show the inverse so stale values never look valid
    task automatic xfer(input logic w, input logic pm, input logic [7:0] pg,
                        input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
        @(negedge core_clk_i);
        {wr_en_o, rd_en_o, pmbus_o, page_o, addr_o, wdata_o} = {w, !w, pm, pg, a, d};
        @(negedge core_clk_i);
        {wr_en_o, rd_en_o, addr_o, wdata_o} = {2'b00, ~a, ~d};
        q = rvalid_i ? rdata_i : 16'hXXXX;
    endtask
endmodule

// *** tb/dac_common_regs_tb_top.sv ***
// self-checking bench for the dac register bank
`timescale 1ns/1ps
module dac_common_regs_tb_top;
    import dac_regs_pkg::*;
    logic core_clk_i, arst_n_i, wr_en_i, rd_en_i, pmbus_i, rvalid_o;
    logic [7:0] page_i, addr_i;
    logic [15:0] wdata_i, rdata_o;
    logic [1:0] sync_cfg_i, clear_value_select_i, load_ch_o;
    logic [1:0] voltage_output_power0_o, voltage_output_power1_o;
    logic [11:0] code0_o, code1_o;
    logic window_compare_hold_o, register_lock_o, dump_read_select_o, int_ref_en_o;
    logic current_output_power0_o, current_output_power1_o, soft_reset_o;
    logic simultaneous_load_o, output_clear_o, fault_dump_o, protect_o;
    logic snapshot_row_read_o, store_program_o, store_reload_o;
    logic [9:0] seen;
    int error_cnt = 0;
    int compares = 0;
    int bit_tab[6] = '{BIT_CLEAR, BIT_DUMP, BIT_PROTECT, BIT_ROW_READ, BIT_PROGRAM, BIT_RELOAD};
    dac_common_regs #(.CODE_BITS(12)) u_dac_common_regs (.*);
    dac_host_model u_dac_host_model (.core_clk_i(core_clk_i), .rvalid_i(rvalid_o),
        .rdata_i(rdata_o), .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .pmbus_o(pmbus_i),
        .page_o(page_i), .addr_o(addr_i), .wdata_o(wdata_i));
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) #1 seen |= {soft_reset_o, simultaneous_load_o, load_ch_o,
        output_clear_o, fault_dump_o, protect_o, snapshot_row_read_o, store_program_o,
        store_reload_o};
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // pulses trail the write by one cycle, so the window is held open
    task automatic w(input logic pm, input logic [7:0] pg, input logic [7:0] a,
                     input logic [15:0] d);
        logic [15:0] q;
        seen = '0;
        u_dac_host_model.xfer(1'b1, pm, pg, a, d, q);
        repeat (3) @(negedge core_clk_i);
    endtask
    task automatic r(input logic [7:0] a, input logic [15:0] exp, input string what);
        logic [15:0] q;
        u_dac_host_model.xfer(1'b0, 1'b0, 8'h00, a, 16'h0000, q);
        chk(what, q, exp);
    endtask
    task automatic test_done();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        {sync_cfg_i, clear_value_select_i, arst_n_i, seen} = '0;
        repeat (10) @(negedge core_clk_i);
        arst_n_i = 1'b1;
        r(ADDR_SETUP, RST_SETUP, "setup reset");
        chk("power reset", {voltage_output_power0_o, current_output_power0_o,
            voltage_output_power1_o, current_output_power1_o}, 16'h003F);
        r(ADDR_CODE1, 16'h0000, "code1 reset");
        r(ADDR_ACTION, 16'h0000, "action reset");
        r(8'h05, 16'h0000, "unmapped read");
        w(1'b0, 8'h00, ADDR_CODE0, 16'hABC0);
        chk("code0", code0_o, 16'h0ABC);
        r(ADDR_CODE0, 16'hABC0, "code0 read");
        w(1'b1, PM_PAGE_CH1, PM_CMD_CODE, 16'h1230);
        chk("code1 paged", code1_o, 16'h0123);
        w(1'b1, PM_PAGE_COMMON, PM_CMD_SETUP, 16'hB000);
        chk("setup fields", {window_compare_hold_o, register_lock_o, dump_read_select_o,
            int_ref_en_o, voltage_output_power0_o, current_output_power0_o,
            voltage_output_power1_o, current_output_power1_o}, 16'h02C0);
        for (int v = 0; v < 4; v++) begin
            w(1'b0, 8'h00, ADDR_SETUP, {4'h0, v[1:0], 1'b1, 6'h00, v[1:0], 1'b0});
            chk("power code", {voltage_output_power0_o, current_output_power0_o,
                voltage_output_power1_o, current_output_power1_o},
                {v[1:0], 1'b1, v[1:0], 1'b0});
        end
        clear_value_select_i = 2'b01;
        for (int i = 0; i < 6; i++) begin
            w(1'b0, 8'h00, ADDR_ACTION, 16'h0001 << bit_tab[i]);
            chk("trigger pulse", seen, 16'h0001 << (5 - i));
        end
        chk("clear code0", code0_o, 16'h0800);
        chk("clear code1", code1_o, 16'h0000);
        r(ADDR_ACTION, 16'h0000, "trigger readback");
        w(1'b0, 8'h00, ADDR_ACTION, 16'h0000);
        chk("zero write", seen, 16'h0000);
        sync_cfg_i = 2'b10;
        w(1'b1, PM_PAGE_COMMON, PM_CMD_ACTION, 16'h0080);
        chk("load select", seen, 16'h0180);
        sync_cfg_i = 2'b01;
        w(1'b0, 8'h00, ADDR_ACTION, 16'h0080);
        chk("load plain", seen, 16'h0140);
        w(1'b0, 8'h00, ADDR_SETUP, 16'h4000);
        chk("locked", register_lock_o, 16'h0001);
        w(1'b0, 8'h00, ADDR_CODE0, 16'h5550);
        chk("locked code", code0_o, 16'h0800);
        w(1'b0, 8'h00, ADDR_ACTION, 16'h3010);
        chk("locked trigger", seen, 16'h0000);
        w(1'b0, 8'h00, ADDR_SETUP, 16'h0000);
        chk("bad password", register_lock_o, 16'h0001);
        w(1'b0, 8'h00, ADDR_ACTION, 16'h5000);
        w(1'b0, 8'h00, ADDR_SETUP, 16'h0000);
        chk("unlocked", register_lock_o, 16'h0000);
        w(1'b0, 8'h00, ADDR_CODE0, 16'h7770);
        w(1'b0, 8'h00, ADDR_ACTION, 16'h0A00);
        chk("soft reset", seen[9], 16'h0001);
        chk("reset code0", code0_o, 16'h0000);
        r(ADDR_SETUP, RST_SETUP, "setup after reset");
        test_done();
    end
endmodule
